//--- lem_monitor.sv
// Eight-lane error monitor and synchronization status registers
//
// Overview of operation
// [R1] Bad-disparity register bit 7 write clears the addressed lane's interrupt; the code keeps it set while the count is at or above the threshold.
// [R2] Bad-disparity register bit 6 write disables the addressed lane's counter.
// [R3] Bad-disparity register bit 5 write zeroes the addressed lane's counter.
// [R4] Bits [2:0] of a command write pick the lane the commands act on.
// [R5] Bad-disparity read gives per-lane flags: count reached threshold.
// [R6] In dual-link mode only low four flag bits serve each link.
// [R7] Counts are not in flag registers; counter readback register returns them.
// [R8] Not-in-table register has the same three commands and threshold flags.
// [R9] Stray-control register has the same three commands; bits [4:3] reserved.
// [R10] Code-group lock register shows one lock bit per lane.
// [R11] Writing bit 7 of lock register clears lock-loss interrupt flag.
// [R12] Code-group lock loss asserts the resync request toward the transmitter.
// [R13] Frame alignment register shows live per-lane frame alignment.
// [R14] Counter readback returns counter chosen by lane and kind selects.
// [R15] Masked-in threshold hit drives active-low interrupt output low.
// [R16] Frame alignment loss starts a new synchronization sequence.
// [R17] Each counter counts every error of its kind while not disabled; the code stops at 255 and drops an error that meets a clear.
// [R18] Software writes lane address and command bit in one write.
`timescale 1ns/1ps
module lem_monitor #(
  parameter int unsigned LANES = lem_pkg::LANES,
  parameter int unsigned CNT_W = lem_pkg::CNT_W
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [10:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [LANES-1:0] disparity_err_i,
  input wire logic [LANES-1:0] invalid_code_err_i,
  input wire logic [LANES-1:0] stray_control_err_i,
  input wire logic [LANES-1:0] code_group_lock_i,
  input wire logic [LANES-1:0] frame_alignment_state_i,
  input wire logic [CNT_W-1:0] error_count_limit_i,
  input wire logic [2:0] irq_mask_i,
  input wire logic dual_link_i,
  input wire logic link_pick_i,
  output logic irq_n_o,
  output logic lock_loss_irq_o,
  output logic link_resync_request_out_n_o
);
  localparam int unsigned K = lem_pkg::KINDS;

  logic [CNT_W-1:0] count [K][LANES];
  logic [LANES-1:0] reached [K];
  logic [LANES-1:0] irq_flag [K];
  logic [LANES-1:0] err_in [K];
  logic [K-1:0] cmd_wr;
  logic [LANES-1:0] lane_hit;
  logic [2:0] counter_lane_pick_ff;
  logic [1:0] counter_kind_pick_ff;
  logic [LANES-1:0] lock_ff;
  logic [LANES-1:0] frame_ff;
  logic lock_irq_ff;
  logic irq_n_ff;
  logic resync_n_ff;
  logic [lem_pkg::RESYNC_CNT_W-1:0] resync_cnt_ff;
  logic [lem_pkg::RESYNC_CNT_W-1:0] nxt_resync_cnt;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [CNT_W-1:0] picked_count;
  logic lock_lost;
  logic frame_lost;
  logic readback_wr;
  logic lock_irq_clear;
  logic all_locked;
  logic resync_hold;

  // Present a per-lane flag byte as seen by the selected link
  function automatic logic [7:0] link_view(input logic [LANES-1:0] flags,
                                           input logic dual, input logic pick);
    logic [7:0] full;
    full = 8'(flags);
    if (dual)
    begin
      link_view = pick ? {4'h0, full[7:4]} : {4'h0, full[3:0]};
    end
    else
    begin
      link_view = full;
    end
  endfunction : link_view

  // Register address of the command register of an error kind
  function automatic logic [10:0] kind_offset(input int unsigned kind);
    case (kind)
      0: kind_offset = lem_pkg::OFS_BAD_DISPARITY;
      1: kind_offset = lem_pkg::OFS_NOT_IN_TABLE;
      default: kind_offset = lem_pkg::OFS_UNEXPECTED_CTRL;
    endcase
  endfunction : kind_offset

  // Write strobe aimed at one register offset
  function automatic logic reg_write_hit(input logic wr, input logic [10:0] addr,
                                         input logic [10:0] offset);
    reg_write_hit = wr && (addr == offset);
  endfunction : reg_write_hit

  assign err_in[0] = disparity_err_i;
  assign err_in[1] = invalid_code_err_i;
  assign err_in[2] = stray_control_err_i;

  // Lane address sits in the same byte as the command bits [R4] [R18]
  assign lane_hit = LANES'(1) << reg_wdata_i[lem_pkg::LANE_PICK_LSB +: lem_pkg::LANE_PICK_W];

  // Readback selection write and lock interrupt clear strobes
  assign readback_wr = reg_write_hit(reg_wr_i, reg_addr_i, lem_pkg::OFS_COUNTER_READBACK);
  assign lock_irq_clear = reg_write_hit(reg_wr_i, reg_addr_i, lem_pkg::OFS_CODE_GROUP_LOCK)
    && reg_wdata_i[lem_pkg::BIT_IRQ_CLEAR]; // [R11]

  // One counter per error kind and lane
  genvar gk;
  genvar gl;
  generate
    for (gk = 0; gk < K; gk++)
    begin : g_kind
      assign cmd_wr[gk] = reg_write_hit(reg_wr_i, reg_addr_i, kind_offset(gk)); // [R8] [R9]
      for (gl = 0; gl < LANES; gl++)
      begin : g_lane
        logic hit;
        assign hit = cmd_wr[gk] && lane_hit[gl]; // [R4]
        lem_lane_counter #(
          .CNT_W(CNT_W)
        ) u_counter (
          .clock_i(clock_i),
          .arst_n_i(arst_n_i),
          .err_i(err_in[gk][gl]), // [R17]
          .clear_i(hit && reg_wdata_i[lem_pkg::BIT_COUNTER_CLEAR]), // [R3]
          .off_wr_i(hit), // [R2]
          .off_val_i(reg_wdata_i[lem_pkg::BIT_COUNTER_OFF]), // [R2]
          .irq_clear_i(hit && reg_wdata_i[lem_pkg::BIT_IRQ_CLEAR]), // [R1]
          .limit_i(error_count_limit_i),
          .count_o(count[gk][gl]),
          .reached_o(reached[gk][gl]), // [R5]
          .irq_o(irq_flag[gk][gl])
        );
      end
    end
  endgenerate

  // Lane and kind selection for the counter readback
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      counter_lane_pick_ff <= '0;
      counter_kind_pick_ff <= '0;
    end
    else if (readback_wr)
    begin
      counter_lane_pick_ff <= reg_wdata_i[lem_pkg::COUNTER_LANE_LSB +: 3]; // [R14]
      counter_kind_pick_ff <=
        reg_wdata_i[lem_pkg::COUNTER_KIND_LSB +: lem_pkg::COUNTER_KIND_W]; // [R14]
    end
  end

  always_comb
  begin
    case (counter_kind_pick_ff)
      lem_pkg::KIND_DISPARITY: picked_count = count[0][counter_lane_pick_ff]; // [R14]
      lem_pkg::KIND_INVALID_CODE: picked_count = count[1][counter_lane_pick_ff];
      lem_pkg::KIND_STRAY_CONTROL: picked_count = count[2][counter_lane_pick_ff];
      default: picked_count = '0;
    endcase
  end

  // Live lane status, sampled every cycle
  // Status reads see the pins one cycle late; loss detection compares that copy with the live pins
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lock_ff <= LANES'(lem_pkg::RESET_LOCK);
      frame_ff <= '0;
    end
    else
    begin
      lock_ff <= code_group_lock_i; // [R10]
      frame_ff <= frame_alignment_state_i; // [R13]
    end
  end

  assign lock_lost = |(lock_ff & ~code_group_lock_i);
  assign frame_lost = |(frame_ff & ~frame_alignment_state_i);
  assign all_locked = &code_group_lock_i;

  // Lock-loss interrupt flag; a new loss wins over the clear
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lock_irq_ff <= 1'b0;
    end
    else if (lock_lost)
    begin
      lock_irq_ff <= 1'b1;
    end
    else if (lock_irq_clear)
    begin
      lock_irq_ff <= 1'b0; // [R11]
    end
  end

  // Hold timer that restarts synchronization after frame alignment loss
  always_comb
  begin
    if (frame_lost)
    begin
      nxt_resync_cnt = lem_pkg::RESYNC_CNT_W'(lem_pkg::RESYNC_HOLD_CYCLES); // [R16]
    end
    else if (resync_cnt_ff != '0)
    begin
      nxt_resync_cnt = resync_cnt_ff - 1'b1;
    end
    else
    begin
      nxt_resync_cnt = resync_cnt_ff;
    end
  end

  // Timer still running after this edge
  assign resync_hold = (nxt_resync_cnt != '0);

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      resync_cnt_ff <= '0;
    end
    else
    begin
      resync_cnt_ff <= nxt_resync_cnt;
    end
  end

  // Request is active low: held while any lane lacks lock or the timer runs
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      resync_n_ff <= 1'b0;
    end
    else
    begin
      resync_n_ff <= all_locked && !resync_hold; // [R12] [R16]
    end
  end

  // Interrupt output, active low
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_n_ff <= 1'b1;
    end
    else
    begin
      irq_n_ff <= !((irq_mask_i[0] && |irq_flag[0]) // [R15]
                    || (irq_mask_i[1] && |irq_flag[1])
                    || (irq_mask_i[2] && |irq_flag[2]));
    end
  end

  // Read data; unmapped addresses and write-only fields read as zero
  always_comb
  begin
    case (reg_addr_i)
      lem_pkg::OFS_COUNTER_READBACK: nxt_rdata = 8'(picked_count); // [R7] [R14]
      lem_pkg::OFS_BAD_DISPARITY:
        nxt_rdata = link_view(reached[0], dual_link_i, link_pick_i); // [R5] [R6]
      lem_pkg::OFS_NOT_IN_TABLE:
        nxt_rdata = link_view(reached[1], dual_link_i, link_pick_i); // [R8] [R6]
      lem_pkg::OFS_UNEXPECTED_CTRL: nxt_rdata = lem_pkg::RESET_BYTE; // [R9]
      lem_pkg::OFS_CODE_GROUP_LOCK: nxt_rdata = 8'(lock_ff); // [R10]
      lem_pkg::OFS_FRAME_ALIGNMENT: nxt_rdata = 8'(frame_ff); // [R13]
      default: nxt_rdata = lem_pkg::RESET_BYTE;
    endcase
  end

  // Captured at the read strobe and held until the next read
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_ff <= lem_pkg::RESET_BYTE;
    end
    else if (reg_rd_i)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign irq_n_o = irq_n_ff;
  assign lock_loss_irq_o = lock_irq_ff;
  assign link_resync_request_out_n_o = resync_n_ff;
endmodule : lem_monitor

//--- lem_pkg.sv
// Constants shared by the lane error monitor
package lem_pkg;
  localparam int unsigned LANES = 8;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned KINDS = 3;

  // Register offsets
  localparam logic [10:0] OFS_COUNTER_READBACK = 11'h46b;
  localparam logic [10:0] OFS_BAD_DISPARITY = 11'h46d;
  localparam logic [10:0] OFS_NOT_IN_TABLE = 11'h46e;
  localparam logic [10:0] OFS_UNEXPECTED_CTRL = 11'h46f;
  localparam logic [10:0] OFS_CODE_GROUP_LOCK = 11'h470;
  localparam logic [10:0] OFS_FRAME_ALIGNMENT = 11'h471;

  // Command register fields
  localparam int unsigned BIT_IRQ_CLEAR = 7;
  localparam int unsigned BIT_COUNTER_OFF = 6;
  localparam int unsigned BIT_COUNTER_CLEAR = 5;
  localparam int unsigned LANE_PICK_LSB = 0;
  localparam int unsigned LANE_PICK_W = 3;

  // Counter readback selection fields
  localparam int unsigned COUNTER_LANE_LSB = 4;
  localparam int unsigned COUNTER_KIND_LSB = 0;
  localparam int unsigned COUNTER_KIND_W = 2;

  // Error kinds, also the readback kind selection codes
  localparam logic [1:0] KIND_DISPARITY = 2'h0;
  localparam logic [1:0] KIND_INVALID_CODE = 2'h1;
  localparam logic [1:0] KIND_STRAY_CONTROL = 2'h2;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_LOCK = 8'h00;

  // Resync request hold after a frame alignment loss
  localparam int unsigned CLOCK_MHZ = 200;
  localparam int unsigned RESYNC_HOLD_NS = 100;
  localparam int unsigned RESYNC_HOLD_CYCLES =
    (RESYNC_HOLD_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned RESYNC_CNT_W = 8;
endpackage : lem_pkg

//--- lem_lane_counter.sv
// One error counter of one lane with threshold flag and sticky interrupt flag
`timescale 1ns/1ps
module lem_lane_counter #(
  parameter int unsigned CNT_W = 8
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic err_i,
  input wire logic clear_i,
  input wire logic off_wr_i,
  input wire logic off_val_i,
  input wire logic irq_clear_i,
  input wire logic [CNT_W-1:0] limit_i,
  output logic [CNT_W-1:0] count_o,
  output logic reached_o,
  output logic irq_o
);
  logic [CNT_W-1:0] count_ff;
  logic off_ff;
  logic irq_ff;
  logic reached;

  assign reached = (count_ff >= limit_i);
  assign count_o = count_ff;
  assign reached_o = reached;
  assign irq_o = irq_ff;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      off_ff <= 1'b0;
    end
    else if (off_wr_i)
    begin
      off_ff <= off_val_i;
    end
  end

  // Saturating count; a clear command takes precedence over a new error
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      count_ff <= '0;
    end
    else if (clear_i)
    begin
      count_ff <= '0;
    end
    else if (err_i && !off_ff && (count_ff != {CNT_W{1'b1}}))
    begin
      count_ff <= count_ff + 1'b1;
    end
  end

  // Threshold interrupt flag: a reached threshold wins over the clear
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_ff <= 1'b0;
    end
    else if (reached)
    begin
      irq_ff <= 1'b1;
    end
    else if (irq_clear_i)
    begin
      irq_ff <= 1'b0;
    end
  end
endmodule : lem_lane_counter

//--- lem_tx_model.sv
// Transmitter model that sends bursts of lane errors
`timescale 1ns/1ps
module lem_tx_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic send_i,
  input wire logic [1:0] kind_i,
  input wire logic [2:0] lane_i,
  input wire logic [7:0] len_i,
  output logic [7:0] disparity_err_o,
  output logic [7:0] invalid_code_err_o,
  output logic [7:0] stray_control_err_o,
  output logic busy_o
);
  logic [7:0] left_ff;
  logic [1:0] kind_ff;
  logic [7:0] lane_ff;
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      left_ff <= 8'h00;
    else if (send_i)
      left_ff <= len_i;
    else if (busy_o)
      left_ff <= left_ff - 8'h01;
  end
  always_ff @(posedge clock_i)
  begin
    if (send_i)
    begin
      kind_ff <= kind_i;
      lane_ff <= 8'h01 << lane_i;
    end
  end
  assign busy_o = left_ff != 8'h00;
  // Errors come back to back, one per remaining count
  assign disparity_err_o = (busy_o && kind_ff == 2'h0) ? lane_ff : 8'h00;
  assign invalid_code_err_o = (busy_o && kind_ff == 2'h1) ? lane_ff : 8'h00;
  assign stray_control_err_o = (busy_o && kind_ff == 2'h2) ? lane_ff : 8'h00;
endmodule : lem_tx_model

//--- lem_monitor_sva.sv
// Checker for the lane error monitor ports
`timescale 1ns/1ps
module lem_monitor_sva #(
  parameter int unsigned LANES = 8,
  parameter int unsigned CNT_W = 8
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [10:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [LANES-1:0] code_group_lock_i,
  input wire logic [LANES-1:0] frame_alignment_state_i,
  input wire logic [CNT_W-1:0] error_count_limit_i,
  input wire logic [2:0] irq_mask_i,
  input wire logic dual_link_i,
  input wire logic irq_n_o,
  input wire logic lock_loss_irq_o,
  input wire logic link_resync_request_out_n_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_frame_drop;
    |($past(frame_alignment_state_i) & ~frame_alignment_state_i);
  endsequence
  sequence s_resync_held;
    !link_resync_request_out_n_o [*8];
  endsequence
  property p_frame_resync;
    s_frame_drop |-> ##2 s_resync_held;
  endproperty
  a_frame_resync: assert property (p_frame_resync) else $error("resync not held");
  property p_lock_resync;
    !(&code_group_lock_i) |-> ##[1:2] !link_resync_request_out_n_o;
  endproperty
  a_lock_resync: assert property (p_lock_resync) else $error("no resync on unlock");
  property p_loss_set;
    |($past(code_group_lock_i) & ~code_group_lock_i) |-> ##[1:2] lock_loss_irq_o;
  endproperty
  a_loss_set: assert property (p_loss_set) else $error("lock loss flag not set");
  property p_loss_clear;
    reg_wr_i && reg_addr_i == lem_pkg::OFS_CODE_GROUP_LOCK && reg_wdata_i[7]
      && (&code_group_lock_i) && (&$past(code_group_lock_i))
      && (&$past(code_group_lock_i, 2)) |=> !lock_loss_irq_o;
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("lock loss flag kept");
  property p_lock_read;
    reg_rd_i && reg_addr_i == lem_pkg::OFS_CODE_GROUP_LOCK && $stable(code_group_lock_i)
      |=> reg_rdata_o == $past(code_group_lock_i);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read wrong");
  property p_frame_read;
    reg_rd_i && reg_addr_i == lem_pkg::OFS_FRAME_ALIGNMENT
      && $stable(frame_alignment_state_i) |=> reg_rdata_o == $past(frame_alignment_state_i);
  endproperty
  a_frame_read: assert property (p_frame_read) else $error("frame read wrong");
  property p_irq_mask;
    !irq_n_o |-> |$past(irq_mask_i);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
  property p_limit_zero;
    reg_rd_i && reg_addr_i == lem_pkg::OFS_BAD_DISPARITY && error_count_limit_i == 0
      && $stable(error_count_limit_i) && !dual_link_i |=> reg_rdata_o == 8'hff;
  endproperty
  a_limit_zero: assert property (p_limit_zero) else $error("flags wrong at zero limit");
  property p_stray_read;
    reg_rd_i && reg_addr_i == lem_pkg::OFS_UNEXPECTED_CTRL |=> reg_rdata_o == 8'h00;
  endproperty
  a_stray_read: assert property (p_stray_read) else $error("stray register read");
endmodule : lem_monitor_sva
bind lem_monitor lem_monitor_sva #(.LANES(LANES), .CNT_W(CNT_W)) u_sva (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .code_group_lock_i(code_group_lock_i), .frame_alignment_state_i(frame_alignment_state_i),
  .error_count_limit_i(error_count_limit_i), .irq_mask_i(irq_mask_i),
  .dual_link_i(dual_link_i), .irq_n_o(irq_n_o), .lock_loss_irq_o(lock_loss_irq_o),
  .link_resync_request_out_n_o(link_resync_request_out_n_o));

//--- jesd204b_lane_error_monitor_tb_top.sv
// Testbench for the lane error monitor
`timescale 1ns/1ps
module jesd204b_lane_error_monitor_tb_top;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [10:0] addr = 11'h000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, d_err, n_err, s_err;
  logic [7:0] lock = 8'h00;
  logic [7:0] frame = 8'h00;
  logic [7:0] limit = 8'h03;
  logic [2:0] mask = 3'h0;
  logic dual = 1'b0;
  logic pick = 1'b0;
  logic irq_n, loss, resync_n, busy;
  logic send = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [2:0] lane = 3'h0;
  logic [7:0] len = 8'h00;
  logic [10:0] ofs [3];
  int error_cnt = 0;
  int samples_checked = 0;
  always #2.5 clock_i = ~clock_i;
  lem_monitor dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .disparity_err_i(d_err), .invalid_code_err_i(n_err), .stray_control_err_i(s_err),
    .code_group_lock_i(lock), .frame_alignment_state_i(frame), .error_count_limit_i(limit),
    .irq_mask_i(mask), .dual_link_i(dual), .link_pick_i(pick), .irq_n_o(irq_n),
    .lock_loss_irq_o(loss), .link_resync_request_out_n_o(resync_n));
  lem_tx_model u_tx (.clock_i(clock_i), .arst_n_i(arst_n_i), .send_i(send), .kind_i(kind),
    .lane_i(lane), .len_i(len), .disparity_err_o(d_err), .invalid_code_err_o(n_err),
    .stray_control_err_o(s_err), .busy_o(busy));
  task complete_run;
    $display("Checked %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step
  task wreg(input logic [10:0] a, input logic [7:0] d);
    step(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
  endtask : wreg
  task rchk(input logic [10:0] a, input logic [7:0] exp);
    step(1);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    check(rdata, exp);
  endtask : rchk
  task cnt_chk(input logic [2:0] l, input logic [1:0] k, input logic [7:0] exp);
    wreg(lem_pkg::OFS_COUNTER_READBACK, {1'b0, l, 2'b00, k});
    rchk(lem_pkg::OFS_COUNTER_READBACK, exp);
  endtask : cnt_chk
  task inject(input logic [1:0] k, input logic [2:0] l, input logic [7:0] n);
    step(1);
    kind = k;
    lane = l;
    len = n;
    send = 1'b1;
    step(1);
    send = 1'b0;
    for (int i = 0; i < 300 && busy; i++)
      step(1);
    if (busy)
    begin
      error_cnt++;
      $display("Error at %0t: burst never ended", $time);
      complete_run();
    end
  endtask : inject
  initial
  begin
    ofs[0] = lem_pkg::OFS_BAD_DISPARITY;
    ofs[1] = lem_pkg::OFS_NOT_IN_TABLE;
    ofs[2] = lem_pkg::OFS_UNEXPECTED_CTRL;
    step(16);
    arst_n_i = 1'b1;
    for (int i = 0; i < 5; i++)
      rchk(lem_pkg::OFS_BAD_DISPARITY + 11'(i), lem_pkg::RESET_BYTE);
    lock = 8'hff;
    frame = 8'hff;
    step(25);
    check({7'h00, resync_n}, 8'h01);
    rchk(lem_pkg::OFS_CODE_GROUP_LOCK, 8'hff);
    rchk(lem_pkg::OFS_FRAME_ALIGNMENT, 8'hff);
    lock = 8'hf7;
    step(3);
    check({7'h00, resync_n}, 8'h00);
    check({7'h00, loss}, 8'h01);
    rchk(lem_pkg::OFS_CODE_GROUP_LOCK, 8'hf7);
    lock = 8'hff;
    step(3);
    wreg(lem_pkg::OFS_CODE_GROUP_LOCK, 8'h80);
    step(2);
    check({7'h00, loss}, 8'h00);
    frame = 8'hfe;
    rchk(lem_pkg::OFS_FRAME_ALIGNMENT, 8'hfe);
    frame = 8'hff;
    check({7'h00, resync_n}, 8'h00);
    step(25);
    check({7'h00, resync_n}, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      mask = 3'h1 << k;
      inject(2'(k), 3'(k + 1), 8'h03);
      rchk(ofs[k], (k == 2) ? 8'h00 : 8'h01 << (k + 1));
      cnt_chk(3'(k + 1), 2'(k), 8'h03);
      check({7'h00, irq_n}, 8'h00);
      wreg(ofs[k], 8'h20 | 8'(k + 1));
      cnt_chk(3'(k + 1), 2'(k), 8'h00);
      wreg(ofs[k], 8'hc0 | 8'(k + 1));
      inject(2'(k), 3'(k + 1), 8'h02);
      cnt_chk(3'(k + 1), 2'(k), 8'h00);
      check({7'h00, irq_n}, 8'h01);
      wreg(ofs[k], 8'(k + 1));
      inject(2'(k), 3'(k + 1), 8'h01);
      cnt_chk(3'(k + 1), 2'(k), 8'h01);
    end
    mask = 3'h0;
    cnt_chk(3'h1, 2'h3, 8'h00);
    inject(2'h0, 3'h6, 8'h03);
    dual = 1'b1;
    pick = 1'b1;
    rchk(lem_pkg::OFS_BAD_DISPARITY, 8'h04);
    pick = 1'b0;
    rchk(lem_pkg::OFS_BAD_DISPARITY, 8'h00);
    dual = 1'b0;
    limit = 8'h00;
    rchk(lem_pkg::OFS_BAD_DISPARITY, 8'hff);
    limit = 8'h03;
    rchk(11'h400, 8'h00);
    complete_run();
  end
endmodule : jesd204b_lane_error_monitor_tb_top
